// file: core/cpf_regs.svh
// register offsets, field positions, reset values and timing counts for card power control
`ifndef CPF_REGS_SVH
`define CPF_REGS_SVH
`define CPF_ADDR_CTRL 8'h00
`define CPF_ADDR_STAT 8'h04
`define CPF_ADDR_IRQ_STAT 8'h08
`define CPF_ADDR_IRQ_MASK 8'h0c
`define CPF_CTRL_VSEL 0
`define CPF_CTRL_RESET 32'h0000_0000
`define CPF_EV_OVERCUR 0
`define CPF_EV_VDD_FAULT 1
`define CPF_EV_VCC_FAULT 2
`define CPF_EV_RECOVERED 3
`define CPF_EV_IGNORED 4
`define CPF_EV_WIDTH 5
`define CPF_MASK_RESET 5'h00
`define CPF_CLK_MHZ 125
`define CPF_STAB_TIME_MS 10
`define CPF_STAB_CYCLES (`CPF_STAB_TIME_MS * 1000 * `CPF_CLK_MHZ)
`endif

// file: core/cpf_pkg.sv
// types shared by the card power control design
package cpf_pkg;
    typedef enum logic [2:0] {
        ST_POR,
        ST_LOW_POWER,
        ST_STABILIZE,
        ST_IDLE,
        ST_SESSION,
        ST_DEACT
    } cpf_state_t;
endpackage

// file: core/cpf_sync3.sv
// three-stage synchroniser, change accepted when last two stages agree
module cpf_sync3 (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic async_in,
    input wire logic reset_val_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } cpf_sync_t;
    cpf_sync_t st_q, st_d;
    // shift chain and agreement filter
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign level_out = st_q.lvl ^ reset_val_in;
endmodule // cpf_sync3

// file: core/cpf_stab_timer.sv
// stabilization down-counter, loaded on request, done pulse at expiry
`include "cpf_regs.svh"
module cpf_stab_timer #(
    parameter int unsigned STAB_CYCLES = `CPF_STAB_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic load_in,
    output logic busy_out,
    output logic done_out
);
    typedef struct packed {
        logic [23:0] cnt;
        logic busy;
        logic done;
    } cpf_tmr_t;
    cpf_tmr_t st_q, st_d;
    // count down; done pulses in the cycle after the last count
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (load_in)
        begin
            st_d.cnt = 24'(STAB_CYCLES - 1);
            st_d.busy = 1'b1;
        end
        else if (st_q.busy)
        begin
            if (st_q.cnt == 24'h000000)
            begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt - 24'h000001;
            end
        end
    end
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign busy_out = st_q.busy;
    assign done_out = st_q.done;
endmodule // cpf_stab_timer

// file: core/cpf_top.sv
// power-down, fault and voltage-select control of a card interface
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`include "cpf_regs.svh"
// Operation
// - a high power-down request in idle or stabilization puts the block in its low-power state with analog, oscillators and converter off;
//   the code enters it from idle only while the activation request is high.
// - card presence detection keeps working in low power so card insertion drives the interrupt high.
// - normal operation resumes only after the 10 ms stabilization once power-down falls.
// - with a card present the interrupt goes high exactly as stabilization ends.
// - activation falls during power-down or stabilization are ignored and the card stays inactive.
// - activation is edge-sensitive, so the host re-toggles it after stabilization to start a session.
// - an over-current starts deactivation and drives the interrupt low.
// - a fault from either supply supervisor starts deactivation.
// - the host supply supervisor resets the sequencer at power-on and forces deactivation on a fault.
// - the sequencer enables the converter and the voltage select picks 5 V or 3 V.
// - in idle and low power the interrupt shows card presence, inside a session a low level marks a fault.
module cpf_top #(
    parameter int unsigned STAB_CYCLES = `CPF_STAB_CYCLES
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic POWER_DOWN_REQUEST_IN,
    input wire logic ACTIVATION_REQUEST_N_IN,
    input wire logic CARD_PRESENT_DETECT_IN,
    input wire logic CARD_VOLTAGE_SELECT_IN,
    input wire logic OVER_CURRENT_IN,
    input wire logic VDD_OK_IN,
    input wire logic VCC_OK_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic LOW_POWER_STATE_OUT,
    output logic CONVERTER_ENABLE_OUT,
    output logic CONVERTER_5V_OUT,
    output logic DEACTIVATE_OUT,
    output logic INTERRUPT_N_OUT,
    output logic IRQ_OUT
);
    typedef struct packed {
        cpf_pkg::cpf_state_t state;
        logic act_prev;
        logic vsel_cfg;
        logic [`CPF_EV_WIDTH-1:0] irq_stat;
        logic [`CPF_EV_WIDTH-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic low_power;
        logic conv_en;
        logic conv_5v;
        logic deact;
        logic int_n;
        logic irq;
        logic vdd_prev;
    } cpf_top_t;

    cpf_top_t st_q, st_d;
    logic power_down_request_s, act_n_s, card_present_detect_s, ocur_s, vdd_s, vcc_s, vsel_s;
    logic tmr_load, tmr_busy, tmr_done;
    logic act_fall, fault, wr, rd;
    logic [`CPF_EV_WIDTH-1:0] ev;
    logic [5:0] pin_raw;
    logic [5:0] pin_s;

    // pin synchronisers; activation request idles high
    assign pin_raw = {CARD_VOLTAGE_SELECT_IN, VCC_OK_IN, VDD_OK_IN, OVER_CURRENT_IN,
                      CARD_PRESENT_DETECT_IN, POWER_DOWN_REQUEST_IN};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_sync
            cpf_sync3 u_sync (
                .CLOCK_IN(CLOCK_IN),
                .RST_N_IN(RST_N_IN),
                .async_in(pin_raw[gi]),
                .reset_val_in(1'b0),
                .level_out(pin_s[gi])
            );
        end
    endgenerate
    cpf_sync3 u_sync_act (
        .CLOCK_IN(CLOCK_IN),
        .RST_N_IN(RST_N_IN),
        .async_in(~ACTIVATION_REQUEST_N_IN),
        .reset_val_in(1'b1),
        .level_out(act_n_s)
    );
    assign {vsel_s, vcc_s, vdd_s, ocur_s, card_present_detect_s, power_down_request_s} = pin_s;

    cpf_stab_timer #(
        .STAB_CYCLES(STAB_CYCLES)
    ) u_timer (
        .CLOCK_IN(CLOCK_IN),
        .RST_N_IN(RST_N_IN),
        .load_in(tmr_load),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    // edge and fault decode
    assign act_fall = st_q.act_prev & ~act_n_s;
    assign fault = ocur_s | ~vdd_s | ~vcc_s;
    assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ~st_q.ack;
    assign rd = WB_CYC_IN & WB_STB_IN & ~WB_WE_IN & ~st_q.ack;

    // load on power-down release or supervisor release
    always_comb
    begin
        tmr_load = 1'b0;
        if (st_q.state == cpf_pkg::ST_LOW_POWER && !power_down_request_s)
        begin
            tmr_load = 1'b1;
        end
        if (st_q.state == cpf_pkg::ST_POR && vdd_s)
        begin
            tmr_load = 1'b1;
        end
    end

    // main sequencer, interrupt and register file
    always_comb
    begin
        st_d = st_q;
        st_d.act_prev = act_n_s;
        st_d.vdd_prev = vdd_s;
        st_d.ack = 1'b0;
        ev = '0;
        unique case (st_q.state)
            cpf_pkg::ST_POR:
            begin
                if (vdd_s)
                begin
                    st_d.state = cpf_pkg::ST_STABILIZE;
                end
            end
            cpf_pkg::ST_LOW_POWER:
            begin
                if (act_fall)
                begin
                    ev[`CPF_EV_IGNORED] = 1'b1;
                end
                if (!power_down_request_s)
                begin
                    st_d.state = cpf_pkg::ST_STABILIZE;
                end
            end
            cpf_pkg::ST_STABILIZE:
            begin
                if (act_fall)
                begin
                    ev[`CPF_EV_IGNORED] = 1'b1;
                end
                if (power_down_request_s)
                begin
                    st_d.state = cpf_pkg::ST_LOW_POWER;
                end
                else if (tmr_done)
                begin
                    st_d.state = cpf_pkg::ST_IDLE;
                    ev[`CPF_EV_RECOVERED] = 1'b1;
                end
            end
            cpf_pkg::ST_IDLE:
            begin
                if (power_down_request_s && act_n_s)
                begin
                    st_d.state = cpf_pkg::ST_LOW_POWER;
                end
                else if (act_fall && card_present_detect_s && !fault)
                begin
                    st_d.state = cpf_pkg::ST_SESSION;
                end
            end
            cpf_pkg::ST_SESSION:
            begin
                if (fault || !card_present_detect_s)
                begin
                    st_d.state = cpf_pkg::ST_DEACT;
                    ev[`CPF_EV_OVERCUR] = ocur_s;
                    ev[`CPF_EV_VDD_FAULT] = ~vdd_s;
                    ev[`CPF_EV_VCC_FAULT] = ~vcc_s;
                end
                else if (act_n_s)
                begin
                    st_d.state = cpf_pkg::ST_IDLE;
                end
            end
            cpf_pkg::ST_DEACT:
            begin
                if (act_n_s)
                begin
                    st_d.state = cpf_pkg::ST_IDLE; // host ends the session
                end
            end
            default:
            begin
                st_d.state = cpf_pkg::ST_POR;
            end
        endcase
        if (!vdd_s)
        begin
            st_d.state = cpf_pkg::ST_POR;
        end
        // outputs of the sequencer
        st_d.low_power = (st_d.state == cpf_pkg::ST_LOW_POWER);
        st_d.conv_en = (st_d.state == cpf_pkg::ST_SESSION);
        st_d.conv_5v = st_q.vsel_cfg | vsel_s;
        st_d.deact = (st_d.state == cpf_pkg::ST_DEACT);
        // host-supply loss in a session still shows deactivation while held in power-on
        if (st_d.state == cpf_pkg::ST_POR && (st_q.deact || st_q.state == cpf_pkg::ST_SESSION))
        begin
            st_d.deact = 1'b1;
        end
        if (st_d.state == cpf_pkg::ST_SESSION || st_d.state == cpf_pkg::ST_DEACT)
        begin
            st_d.int_n = (st_d.state == cpf_pkg::ST_SESSION);
        end
        else if (st_d.state == cpf_pkg::ST_STABILIZE || st_d.state == cpf_pkg::ST_POR)
        begin
            st_d.int_n = 1'b0;
        end
        else
        begin
            st_d.int_n = card_present_detect_s;
        end
        // bus access; set wins over clear
        if (wr)
        begin
            st_d.ack = 1'b1;
            if (WB_ADR_IN == `CPF_ADDR_CTRL && WB_SEL_IN[0])
            begin
                st_d.vsel_cfg = WB_DAT_IN[`CPF_CTRL_VSEL];
            end
            if (WB_ADR_IN == `CPF_ADDR_IRQ_MASK && WB_SEL_IN[0])
            begin
                st_d.irq_mask = WB_DAT_IN[`CPF_EV_WIDTH-1:0];
            end
            if (WB_ADR_IN == `CPF_ADDR_IRQ_STAT && WB_SEL_IN[0])
            begin
                st_d.irq_stat = st_q.irq_stat & ~WB_DAT_IN[`CPF_EV_WIDTH-1:0];
            end
        end
        st_d.irq_stat = st_d.irq_stat | ev;
        if (rd)
        begin
            st_d.ack = 1'b1;
            unique case (WB_ADR_IN)
                `CPF_ADDR_CTRL: st_d.rdata = {31'h0, st_q.vsel_cfg};
                `CPF_ADDR_STAT: st_d.rdata = {25'h0, st_q.int_n, card_present_detect_s, 2'h0, 3'(st_q.state)};
                `CPF_ADDR_IRQ_STAT: st_d.rdata = {27'h0, st_q.irq_stat};
                `CPF_ADDR_IRQ_MASK: st_d.rdata = {27'h0, st_q.irq_mask};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            st_q <= '0;
            st_q.act_prev <= 1'b1;
            st_q.irq_mask <= `CPF_MASK_RESET;
            st_q.state <= cpf_pkg::ST_POR;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign WB_DAT_OUT = st_q.rdata;
    assign WB_ACK_OUT = st_q.ack;
    assign LOW_POWER_STATE_OUT = st_q.low_power;
    assign CONVERTER_ENABLE_OUT = st_q.conv_en;
    assign CONVERTER_5V_OUT = st_q.conv_5v;
    assign DEACTIVATE_OUT = st_q.deact;
    assign INTERRUPT_N_OUT = st_q.int_n;
    assign IRQ_OUT = st_q.irq;

    // checks
    AST_LOWPWR_ENTRY: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state == cpf_pkg::ST_IDLE && power_down_request_s && act_n_s && vdd_s) |=> LOW_POWER_STATE_OUT)
        else $error("low power not entered");
    AST_NO_CONV_LP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        LOW_POWER_STATE_OUT |-> !CONVERTER_ENABLE_OUT)
        else $error("converter on in low power");
    AST_CARD_PRESENT_DETECT_LP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state == cpf_pkg::ST_LOW_POWER && $past(st_q.state) == cpf_pkg::ST_LOW_POWER)
        |-> INTERRUPT_N_OUT == $past(card_present_detect_s))
        else $error("presence not shown in low power");
    AST_STAB_HOLD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state == cpf_pkg::ST_STABILIZE && tmr_busy) |=> st_q.state != cpf_pkg::ST_IDLE)
        else $error("left stabilization early");
    AST_RECOVER_INT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state == cpf_pkg::ST_STABILIZE && tmr_done && !power_down_request_s && vdd_s && card_present_detect_s)
        |=> INTERRUPT_N_OUT && $rose(INTERRUPT_N_OUT))
        else $error("interrupt not raised at recovery");
    AST_IGNORE_ACT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state inside {cpf_pkg::ST_LOW_POWER, cpf_pkg::ST_STABILIZE}) |=> !CONVERTER_ENABLE_OUT)
        else $error("activation accepted too early");
    AST_FAULT_DEACT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (st_q.state == cpf_pkg::ST_SESSION && fault) |=> DEACTIVATE_OUT && !INTERRUPT_N_OUT)
        else $error("fault did not deactivate");
    AST_VDD_RESET: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !vdd_s |=> st_q.state == cpf_pkg::ST_POR && !CONVERTER_ENABLE_OUT)
        else $error("supply fault did not reset sequencer");
    AST_VSEL: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        ##1 CONVERTER_5V_OUT == ($past(vsel_s) | $past(st_q.vsel_cfg)))
        else $error("voltage select not followed");
endmodule // cpf_top

// file: verif/cpf_host_model.sv
// host controller model driving the power-down and activation pins
module cpf_host_model (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic pd_cmd_in,
    input wire logic act_cmd_in,
    input wire logic rude_in,
    output logic pd_out,
    output logic act_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // power-down only outside a session, activation only out of power-down, unless told to misbehave
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            pd_out <= 1'b0;
            act_n_out <= 1'b1;
        end
        else
        begin
            pd_out <= pd_cmd_in && (act_n_out || rude_in);
            act_n_out <= !(act_cmd_in && (!pd_out || rude_in));
        end
    end
endmodule // cpf_host_model

// file: verif/tb_cpf_top.sv
// self-checking bench for the card power-down and fault control block
`include "cpf_regs.svh"
module tb_cpf_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STAB = 20;
    logic clk, rst_n, card_present_detect, vsel, ovc, vdd_ok, vcc_ok, cyc, stb, we, ack;
    logic pd_cmd, act_cmd, rude, pd, act_n, lp, cen, c5v, deact, int_n, irq;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, rd;
    int n_fail, checked;
    cpf_top #(.STAB_CYCLES(STAB)) u_cpf_top (.CLOCK_IN(clk), .RST_N_IN(rst_n), .POWER_DOWN_REQUEST_IN(pd),
        .ACTIVATION_REQUEST_N_IN(act_n), .CARD_PRESENT_DETECT_IN(card_present_detect), .CARD_VOLTAGE_SELECT_IN(vsel),
        .OVER_CURRENT_IN(ovc), .VDD_OK_IN(vdd_ok), .VCC_OK_IN(vcc_ok), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .LOW_POWER_STATE_OUT(lp), .CONVERTER_ENABLE_OUT(cen), .CONVERTER_5V_OUT(c5v),
        .DEACTIVATE_OUT(deact), .INTERRUPT_N_OUT(int_n), .IRQ_OUT(irq));
    cpf_host_model u_cpf_host_model (.CLOCK_IN(clk), .RST_N_IN(rst_n), .pd_cmd_in(pd_cmd),
        .act_cmd_in(act_cmd), .rude_in(rude), .pd_out(pd), .act_n_out(act_n));
    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one classic wishbone cycle, held until the rising edge that samples ack high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic t_por;
        wt(3);
        chk(int_n, 1'b0, "interrupt low during start-up");
        wt(STAB + 12);
        chk(int_n, 1'b1, "card present after start-up");
        chk(cen, 1'b0, "converter off when idle");
    endtask
    task automatic t_regs;
        bus(1'b0, `CPF_ADDR_CTRL, 32'h0);
        chk(rd, `CPF_CTRL_RESET, "control reset value");
        bus(1'b0, `CPF_ADDR_IRQ_MASK, 32'h0);
        chk(rd, 32'h0, "mask reset value");
        bus(1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        bus(1'b0, `CPF_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0, "unmapped write leaked");
    endtask
    task automatic t_vsel;
        for (int i = 0; i < 2; i++)
        begin
            vsel <= i[0];
            wt(8);
            chk(c5v, i[0], "voltage select pin");
        end
        vsel <= 1'b0;
        bus(1'b1, `CPF_ADDR_CTRL, 32'h1);
        wt(8);
        chk(c5v, 1'b1, "forced 5 V");
        bus(1'b1, `CPF_ADDR_CTRL, 32'h0);
        wt(3);
        chk(c5v, 1'b0, "3 V when nothing asks 5 V");
        vsel <= 1'b1;
    endtask
    task automatic t_overcur;
        bus(1'b1, `CPF_ADDR_IRQ_STAT, 32'h1f);
        bus(1'b1, `CPF_ADDR_IRQ_MASK, 32'h01);
        act_cmd <= 1'b1;
        wt(10);
        chk(cen, 1'b1, "session started");
        chk(int_n, 1'b1, "no fault in session");
        ovc <= 1'b1;
        wt(10);
        chk(deact, 1'b1, "over-current deactivates");
        chk(int_n, 1'b0, "over-current reported");
        chk(cen, 1'b0, "converter off on fault");
        chk(irq, 1'b1, "unmasked event interrupt");
        ovc <= 1'b0;
        bus(1'b0, `CPF_ADDR_IRQ_STAT, 32'h0);
        chk(rd[0], 1'b1, "over-current event bit");
        bus(1'b1, `CPF_ADDR_IRQ_STAT, 32'h1);
        wt(2);
        chk(irq, 1'b0, "event cleared");
        act_cmd <= 1'b0;
        wt(10);
        chk(deact, 1'b0, "deactivate ends on host release");
        chk(int_n, 1'b1, "presence shown again");
    endtask
    task automatic t_supply;
        bus(1'b1, `CPF_ADDR_IRQ_MASK, 32'h00);
        for (int i = 0; i < 2; i++)
        begin
            act_cmd <= 1'b1;
            wt(10);
            chk(cen, 1'b1, "session before supply fault");
            vdd_ok <= i[0];
            vcc_ok <= !i[0];
            wt(10);
            chk(deact, 1'b1, "supply fault deactivates");
            chk(cen, 1'b0, "converter off on supply fault");
            chk(irq, 1'b0, "masked event stays quiet");
            vdd_ok <= 1'b1;
            vcc_ok <= 1'b1;
            act_cmd <= 1'b0;
            wt(STAB + 14);
            chk(int_n, 1'b1, "recovered after supply fault");
            bus(1'b0, `CPF_ADDR_IRQ_STAT, 32'h0);
            chk(rd[1 + i], 1'b1, "supply event bit");
        end
        bus(1'b1, `CPF_ADDR_IRQ_MASK, 32'h1f);
        wt(2);
        chk(irq, 1'b1, "unmask raises interrupt");
        bus(1'b1, `CPF_ADDR_IRQ_STAT, 32'h1f);
        wt(2);
        chk(irq, 1'b0, "all events cleared");
    endtask
    task automatic t_pd;
        pd_cmd <= 1'b1;
        wt(10);
        chk(lp, 1'b1, "low-power entered");
        chk(cen, 1'b0, "converter off in low power");
        card_present_detect <= 1'b0;
        wt(10);
        chk(int_n, 1'b0, "no card in low power");
        card_present_detect <= 1'b1;
        wt(10);
        chk(int_n, 1'b1, "insertion seen in low power");
        rude <= 1'b1;
        act_cmd <= 1'b1;
        wt(10);
        chk(cen, 1'b0, "activation ignored in low power");
        pd_cmd <= 1'b0;
        wt(10);
        chk(lp, 1'b0, "low-power left");
        chk(int_n, 1'b0, "interrupt low while stabilizing");
        wt(STAB + 4);
        chk(int_n, 1'b1, "recovery shown by interrupt");
        chk(cen, 1'b0, "held activation takes no effect");
        bus(1'b0, `CPF_ADDR_IRQ_STAT, 32'h0);
        chk(rd[4:3], 2'h3, "ignored and recovered events");
        rude <= 1'b0;
        act_cmd <= 1'b0;
        wt(8);
        act_cmd <= 1'b1;
        wt(10);
        chk(cen, 1'b1, "fresh activation edge starts session");
        act_cmd <= 1'b0;
        wt(10);
        chk(cen, 1'b0, "session closed");
    endtask
    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    // reset then each scenario in turn
    initial
    begin
        {cyc, stb, we, ovc, pd_cmd, act_cmd, rude} = 7'h00;
        {card_present_detect, vsel, vdd_ok, vcc_ok} = 4'hf;
        adr = 8'h00;
        wdat = 32'h0;
        n_fail = 0;
        checked = 0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_por();
        t_regs();
        t_vsel();
        t_overcur();
        t_supply();
        t_pd();
        wrap_up();
    end
endmodule // tb_cpf_top
